// file: hw/scl_fifo.sv
// flip-flop queue with drop-oldest on overflow, delete-last and clear
// assumes the caller never asks for push and unpush in the same cycle
`timescale 1ns/1ps
module scl_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 256
) (
  input  wire logic                       clk_sys,  // system clock
  input  wire logic                       srst,     // sync reset
  input  wire logic                       clr,      // empty the queue
  input  wire logic                       push,     // store din
  input  wire logic [W-1:0]               din,      // data in
  input  wire logic                       pop,      // take head
  input  wire logic                       unpush,   // remove newest
  output logic      [W-1:0]               dout,     // head entry
  output logic      [W-1:0]               last,     // newest entry
  output logic      [$clog2(DEPTH):0]     count,    // fill level
  output logic                            full,     // no room
  output logic                            empty     // nothing stored
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("scl_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          doPop, doUn, drop;

  assign full  = cnt_r == (AW+1)'(DEPTH);
  assign empty = cnt_r == '0;
  assign count = cnt_r;
  assign dout  = mem[rd_r];
  assign last  = mem[wr_r - AW'(1)];

  always_comb begin
    doPop  = pop && !empty;
    doUn   = unpush && !pop && !empty;
    drop   = push && full && !doPop;  // oldest entry is sacrificed
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    cnt_nxt = cnt_r;
    if (clr) begin
      rd_nxt  = '0;
      wr_nxt  = '0;
      cnt_nxt = '0;
    end else begin
      if (push) wr_nxt = wr_r + AW'(1);
      if (doUn) wr_nxt = wr_r - AW'(1);
      if (doPop || drop) rd_nxt = rd_r + AW'(1);
      if (push && !drop) cnt_nxt = cnt_nxt + (AW+1)'(1);
      if (doPop || doUn) cnt_nxt = cnt_nxt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_r  <= '0;
      wr_r  <= '0;
      cnt_r <= '0;
    end else begin
      rd_r  <= rd_nxt;
      wr_r  <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push && !clr) mem[wr_r] <= din;
  end
endmodule

// file: hw/scl_port.sv
// serial command-line front end: receive queue, line editing, flow control, echo
// assumes a byte receiver/transmitter and a line parser, all on clk_sys
//
// How it works
// [RULE1] escape empties the receive queue and answers CR LF
// [RULE2] backspace deletes the newest stored character unless it is CR or LF
// [RULE3] CR or LF ends a line and hands it to the parser
// [RULE4] received characters wait in a 256-entry first-in first-out queue
// [RULE5] overflow drops the oldest; readiness stays low, no pause until drained
// [RULE6] readiness low after reset, high once commands can be accepted
// [RULE7] a terminator drops readiness and sends pause when flow control is on
// [RULE8] further buffered lines are handed on straight after the current one
// [RULE9] when processing ends readiness rises and resume repeats every five seconds
// [RULE10] with flow control off no pause/resume is sent or obeyed
// [RULE11] of the control codes only seven act; the rest are ignored
// [RULE12] after a parsed line is handed on, CR LF is sent
// [RULE13] with flow control on, resume starts and pause halts transmission
// [RULE14] cancel clears both queues and their pointers
// [RULE15] pause logs a query error; after resume, output drains then sends !
// [RULE16] echo mode returns each byte; backspace returns BS SP BS (code echoes only stored characters, CR, LF and BS)
// [RULE17] of a back-to-back CR LF or LF CR only the first is echoed
// [RULE18] with flow control, a terminator answers pause then CR if echo is on
// [RULE19] host sends only after resume and stops on pause
// [RULE20] lost echo characters produce NAK and a query error
// [RULE21] host keeps echo lines within 127 characters and four queries
// [RULE22] host checks echoes, sends escape on mismatch, terminates after checking
// [RULE23] reset settings: flow control on, echo off, prompt off
// [RULE24] with prompt on, CR LF > is sent once the next command is safe
// [RULE25] outgoing characters queue and stall in place while paused
`timescale 1ns/1ps
`include "scl_map.svh"
module scl_port #(
  parameter int          RXQ_DEPTH  = `SCL_RXQ_DEPTH,
  parameter int          TXQ_DEPTH  = `SCL_TXQ_DEPTH,
  parameter int unsigned XON_CYCLES = `SCL_XON_CYCLES
) (
  input  wire logic              clk_sys,   // 250 MHz system clock
  input  wire logic              srst,      // sync reset, active high
  input  wire logic              rxValid,   // received byte offered
  input  wire logic [7:0]        rxData,    // received byte
  output logic                   rxReady,   // byte taken when both high
  output logic                   txValid,   // byte to transmit
  output logic      [7:0]        txData,    // byte to transmit
  input  wire logic              txReady,   // transmitter takes byte
  output logic                   cmdValid,  // line character to parser
  output logic      [7:0]        cmdData,   // line character
  input  wire logic              cmdReady,  // parser takes character
  input  wire logic              cmdDone,   // parser finished a line
  input  wire logic              cfgLoad,   // load cfgIn
  input  wire scl_pkg::scl_cfg_t cfgIn,     // new settings
  output scl_pkg::scl_cfg_t      cfgOut,    // settings in force
  output logic                   dsr,       // ready-for-commands line
  output logic                   queueErr   // query error to log, pulse
);
  if (RXQ_DEPTH != `SCL_RXQ_DEPTH) begin : g_chk
    $error("scl_port: receive queue must hold 256 characters");
  end

  localparam int RCW = $clog2(RXQ_DEPTH) + 1;
  localparam int TCW = $clog2(TXQ_DEPTH) + 1;

  scl_pkg::scl_cfg_t   cfg_r, cfg_nxt;
  scl_pkg::scl_phase_t phase_r, phase_nxt;
  scl_pkg::scl_seq_t   seq_r, seq_nxt;
  logic [RCW-1:0] termCnt_r, termCnt_nxt, rxCount;
  logic [TCW-1:0] txCount;
  logic [7:0]  rxHead, rxLast, txHead;
  logic        halt_r, halt_nxt, bang_r, bang_nxt, nak_r, nak_nxt;
  logic        doneP_r, doneP_nxt, xonP_r, xonP_nxt, ovf_r, ovf_nxt;
  logic        lineOpen_r, lineOpen_nxt, prevTerm_r, prevTerm_nxt;
  logic [7:0]  prevCode_r, prevCode_nxt;
  logic        dsr_r, dsr_nxt, err_r, err_nxt;
  logic        rxPush, rxUn, rxClr, txClr, txPush, rxPop, txPop;
  logic        rxFull, rxEmpty, txFull, txEmpty, xonTick;
  logic        rxAct, isTerm, headTerm, lastTerm, pairSkip, ovfNow;
  logic [1:0]  n;

  assign cfgOut   = cfg_r;
  assign dsr      = dsr_r;
  assign queueErr = err_r;
  assign isTerm   = rxData == `SCL_CR || rxData == `SCL_LF;
  assign headTerm = rxHead == `SCL_CR || rxHead == `SCL_LF;
  assign lastTerm = rxLast == `SCL_CR || rxLast == `SCL_LF;
  assign rxReady  = seq_r.len == 2'h0 && phase_r != scl_pkg::PH_BOOT;
  assign rxAct    = rxValid && rxReady;
  // parser is held off while a received byte edits the queue tail
  assign cmdValid = termCnt_r != '0 && !rxEmpty && !rxAct;  // [RULE3] [RULE8]
  assign cmdData  = rxHead;
  assign rxPop    = cmdValid && cmdReady;
  assign txValid  = !txEmpty && !halt_r;  // [RULE25]
  assign txData   = txHead;
  assign txPop    = txValid && txReady;
  assign pairSkip = isTerm && prevTerm_r && rxData != prevCode_r;
  assign ovfNow   = ovf_r || rxFull;

  scl_fifo #(.W(8), .DEPTH(RXQ_DEPTH)) u_rxq (
    .clk_sys(clk_sys), .srst(srst), .clr(rxClr), .push(rxPush), .din(rxData),
    .pop(rxPop), .unpush(rxUn), .dout(rxHead), .last(rxLast), .count(rxCount),
    .full(rxFull), .empty(rxEmpty)
  );

  scl_fifo #(.W(8), .DEPTH(TXQ_DEPTH)) u_txq (
    .clk_sys(clk_sys), .srst(srst), .clr(txClr), .push(txPush),
    .din(seq_r.chr[0]), .pop(txPop), .unpush(1'b0), .dout(txHead), .last(),
    .count(txCount), .full(txFull), .empty(txEmpty)
  );

  scl_tick #(.CYCLES(XON_CYCLES)) u_xon (
    .clk_sys(clk_sys), .srst(srst),
    .run(phase_r == scl_pkg::PH_READY && cfg_r.xonEn), .tick(xonTick)
  );

  always_comb begin
    cfg_nxt      = cfgLoad ? cfgIn : cfg_r;
    phase_nxt    = phase_r;
    seq_nxt      = seq_r;
    termCnt_nxt  = termCnt_r;
    halt_nxt     = halt_r;
    bang_nxt     = bang_r;
    nak_nxt      = nak_r;
    doneP_nxt    = doneP_r | cmdDone;
    xonP_nxt     = xonP_r | xonTick;  // [RULE9]
    ovf_nxt      = ovf_r;
    lineOpen_nxt = lineOpen_r;
    prevTerm_nxt = prevTerm_r;
    prevCode_nxt = prevCode_r;
    err_nxt      = 1'b0;
    rxPush       = 1'b0;
    rxUn         = 1'b0;
    rxClr        = 1'b0;
    txClr        = 1'b0;
    txPush       = 1'b0;
    n            = 2'h0;
    if (cmdDone) lineOpen_nxt = 1'b0;
    if (rxPop && headTerm) begin
      termCnt_nxt  = termCnt_nxt - RCW'(1);
      lineOpen_nxt = 1'b1;
    end
    if (seq_r.len != 2'h0) begin
      // a full output queue loses the byte; in echo mode that is reported
      if (!txFull) txPush = 1'b1;
      else if (cfg_r.echoEn) nak_nxt = 1'b1;  // [RULE20]
      seq_nxt.chr = {8'h00, seq_r.chr[2:1]};
      seq_nxt.len = seq_r.len - 2'h1;
    end else if (rxAct) begin
      prevTerm_nxt = 1'b0;
      case (rxData)
        `SCL_ESC: begin
          rxClr       = 1'b1;  // [RULE1]
          termCnt_nxt = '0;
          ovf_nxt     = 1'b0;
          seq_nxt     = {2'h2, 8'h00, `SCL_LF, `SCL_CR};  // [RULE1]
        end
        `SCL_CAN: begin
          rxClr       = 1'b1;  // [RULE14]
          txClr       = 1'b1;  // [RULE14]
          termCnt_nxt = '0;
          ovf_nxt     = 1'b0;
          bang_nxt    = 1'b0;
        end
        `SCL_BS: begin
          if (!rxEmpty && !lastTerm) rxUn = 1'b1;  // [RULE2]
          if (cfg_r.echoEn) seq_nxt = {2'h3, `SCL_BS, `SCL_SP, `SCL_BS};  // [RULE16]
        end
        `SCL_XON: begin
          if (cfg_r.xonEn) begin  // [RULE10]
            halt_nxt = 1'b0;  // [RULE13]
            if (halt_r) bang_nxt = 1'b1;  // [RULE15]
          end
        end
        `SCL_XOFF: begin
          if (cfg_r.xonEn) begin  // [RULE10]
            halt_nxt = 1'b1;  // [RULE13]
            err_nxt  = 1'b1;  // [RULE15]
          end
        end
        `SCL_CR, `SCL_LF: begin
          rxPush       = 1'b1;  // [RULE3]
          termCnt_nxt  = termCnt_nxt + RCW'(1);
          prevTerm_nxt = !pairSkip;
          prevCode_nxt = rxData;
          phase_nxt    = scl_pkg::PH_BUSY;  // [RULE7]
          if (cfg_r.xonEn && !ovfNow) begin
            seq_nxt.chr[0] = `SCL_XOFF;  // [RULE7] [RULE5]
            n = 2'h1;
          end
          if (cfg_r.echoEn && !pairSkip) begin
            seq_nxt.chr[n] = cfg_r.xonEn ? `SCL_CR : rxData;  // [RULE17] [RULE18]
            n = n + 2'h1;
          end
          seq_nxt.len = n;
        end
        default: begin
          if (rxData > `SCL_CTL_TOP) begin  // [RULE11]
            rxPush = 1'b1;  // [RULE4]
            if (cfg_r.echoEn) seq_nxt = {2'h1, 16'h0000, rxData};  // [RULE16]
          end
        end
      endcase
      if (rxPush && rxFull) begin
        ovf_nxt = 1'b1;  // [RULE5]
        if (headTerm) termCnt_nxt = termCnt_nxt - RCW'(1);
      end
    end else if (nak_r && !txFull) begin  // report waits for room, else it is lost too
      seq_nxt = {2'h1, 16'h0000, `SCL_NAK};  // [RULE20]
      nak_nxt = 1'b0;
      err_nxt = 1'b1;  // [RULE20]
    end else if (doneP_r) begin
      if (cfg_r.promptEn && termCnt_r == '0) begin
        seq_nxt = {2'h3, `SCL_GT, `SCL_LF, `SCL_CR};  // [RULE24]
      end else begin
        seq_nxt = {2'h2, 8'h00, `SCL_LF, `SCL_CR};  // [RULE12]
      end
      doneP_nxt = cmdDone;
    end else if (xonP_r) begin
      if (cfg_r.xonEn) seq_nxt = {2'h1, 16'h0000, `SCL_XON};  // [RULE9] [RULE10]
      xonP_nxt = xonTick;
    end else if (bang_r && txEmpty && !halt_r) begin
      seq_nxt  = {2'h1, 16'h0000, `SCL_BANG};  // [RULE15]
      bang_nxt = 1'b0;
    end
    if (ovf_r && rxEmpty) ovf_nxt = 1'b0;
    if (!cfg_nxt.xonEn) halt_nxt = 1'b0;  // [RULE10]
    case (phase_r)
      scl_pkg::PH_BOOT: begin
        phase_nxt = scl_pkg::PH_READY;  // [RULE6]
        xonP_nxt  = 1'b1;
      end
      scl_pkg::PH_READY: begin
      end
      scl_pkg::PH_BUSY: begin
        if (termCnt_nxt == '0 && !lineOpen_nxt && !ovf_nxt && !doneP_nxt &&
            phase_nxt == scl_pkg::PH_BUSY) begin
          phase_nxt = scl_pkg::PH_READY;  // [RULE9]
          xonP_nxt  = 1'b1;
        end
      end
      default: phase_nxt = scl_pkg::PH_BOOT;
    endcase
    dsr_nxt = phase_nxt == scl_pkg::PH_READY;  // [RULE6] [RULE5]
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_r      <= `SCL_CFG_RESET;  // [RULE23]
      phase_r    <= scl_pkg::PH_BOOT;
      seq_r      <= '0;
      termCnt_r  <= '0;
      halt_r     <= 1'b0;
      bang_r     <= 1'b0;
      nak_r      <= 1'b0;
      doneP_r    <= 1'b0;
      xonP_r     <= 1'b0;
      ovf_r      <= 1'b0;
      lineOpen_r <= 1'b0;
      prevTerm_r <= 1'b0;
      prevCode_r <= 8'h00;
      dsr_r      <= 1'b0;
      err_r      <= 1'b0;
    end else begin
      cfg_r      <= cfg_nxt;
      phase_r    <= phase_nxt;
      seq_r      <= seq_nxt;
      termCnt_r  <= termCnt_nxt;
      halt_r     <= halt_nxt;
      bang_r     <= bang_nxt;
      nak_r      <= nak_nxt;
      doneP_r    <= doneP_nxt;
      xonP_r     <= xonP_nxt;
      ovf_r      <= ovf_nxt;
      lineOpen_r <= lineOpen_nxt;
      prevTerm_r <= prevTerm_nxt;
      prevCode_r <= prevCode_nxt;
      dsr_r      <= dsr_nxt;
      err_r      <= err_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_escCrLf;
    rxAct && rxData == `SCL_ESC |=> seq_r.len == 2'h2 && seq_r.chr[0] == `SCL_CR
      ##1 seq_r.chr[0] == `SCL_LF && rxCount == '0;
  endproperty
  a_escCrLf: assert property (p_escCrLf) else $error("escape answer wrong");  // [RULE1]

  property p_bsDelete;
    rxAct && rxData == `SCL_BS && !rxEmpty && !lastTerm
      |=> rxCount == $past(rxCount) - RCW'(1);
  endproperty
  a_bsDelete: assert property (p_bsDelete) else $error("backspace kept char");  // [RULE2]

  property p_dsrBoot;
    $fell(srst) |-> !dsr ##1 dsr;
  endproperty
  a_dsrBoot: assert property (p_dsrBoot) else $error("readiness after reset wrong");  // [RULE6]

  property p_termDsr;
    rxAct && isTerm |=> !dsr ##1 !dsr;
  endproperty
  a_termDsr: assert property (p_termDsr) else $error("readiness not dropped");  // [RULE7]

  property p_xoffHalts;
    rxAct && rxData == `SCL_XOFF && cfg_r.xonEn && !cfgLoad
      |=> halt_r && !txValid && queueErr;
  endproperty
  a_xoffHalts: assert property (p_xoffHalts) else $error("pause not obeyed");  // [RULE13]

  property p_noFlowIgnore;
    rxAct && rxData == `SCL_XOFF && !cfg_r.xonEn |=> !halt_r && !queueErr;
  endproperty
  a_noFlowIgnore: assert property (p_noFlowIgnore) else $error("pause obeyed");  // [RULE10]

  property p_cancel;
    rxAct && rxData == `SCL_CAN |=> rxCount == '0 && txCount == '0;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel left data");  // [RULE14]

  property p_bsEcho;
    rxAct && rxData == `SCL_BS && cfg_r.echoEn |=> seq_r.len == 2'h3
      && seq_r.chr[0] == `SCL_BS && seq_r.chr[1] == `SCL_SP && seq_r.chr[2] == `SCL_BS;
  endproperty
  a_bsEcho: assert property (p_bsEcho) else $error("backspace echo wrong");  // [RULE16]

  property p_ovfNoXoff;
    rxAct && isTerm && ovfNow && !cfg_r.echoEn |=> seq_r.len == 2'h0 && !dsr;
  endproperty
  a_ovfNoXoff: assert property (p_ovfNoXoff) else $error("pause sent in overflow");  // [RULE5]
endmodule

// file: hw/scl_tick.sv
// periodic one-cycle enable pulse while run is high
// assumes CYCLES counts clk_sys periods; restarting run restarts the period
`timescale 1ns/1ps
module scl_tick #(
  parameter int unsigned CYCLES = 1000
) (
  input  wire logic clk_sys,  // system clock
  input  wire logic srst,     // sync reset
  input  wire logic run,      // count while high
  output logic      tick      // pulse at end of each period
);
  localparam int W = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_chk
    $error("scl_tick: CYCLES must be at least 1");
  end

  logic [W-1:0] cnt_r, cnt_nxt;
  logic         tick_r, tick_nxt;

  assign tick = tick_r;

  always_comb begin
    cnt_nxt  = cnt_r + W'(1);
    tick_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = '0;
    end else if (cnt_r == W'(CYCLES - 1)) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule

// file: include/scl_map.svh
// character codes, queue sizes, reset values and timing for the serial command-line port
// assumes an 8-bit character stream and a single 250 MHz clock
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH
`define SCL_CR            8'h0D
`define SCL_LF            8'h0A
`define SCL_BS            8'h08
`define SCL_ESC           8'h1B
`define SCL_XON           8'h11
`define SCL_XOFF          8'h13
`define SCL_CAN           8'h18
`define SCL_NAK           8'h15
`define SCL_SP            8'h20
`define SCL_BANG          8'h21
`define SCL_GT            8'h3E
`define SCL_CTL_TOP       8'h1F
`define SCL_RXQ_DEPTH     256
`define SCL_TXQ_DEPTH     64
`define SCL_CLK_HZ        250000000
`define SCL_XON_PERIOD_S  5
`define SCL_XON_CYCLES    (`SCL_XON_PERIOD_S * `SCL_CLK_HZ)
// cfg bits: [2] flow control, [1] echo, [0] prompt
`define SCL_CFG_RESET     3'h4
`endif

// file: include/scl_pkg.sv
// types shared by the serial command-line port files
// assumes scl_map.svh supplies the numeric constants
package scl_pkg;
  typedef struct packed {
    logic xonEn;
    logic echoEn;
    logic promptEn;
  } scl_cfg_t;

  typedef enum logic [1:0] {PH_BOOT, PH_READY, PH_BUSY} scl_phase_t;

  typedef struct packed {
    logic [1:0]      len;
    logic [2:0][7:0] chr;
  } scl_seq_t;
endpackage

// file: verification/scl_host.sv
// host terminal model: offers bytes, obeys pause/resume, records what the port sends
// assumes the port byte handshake on clk_sys; the bench calls send()
`timescale 1ns/1ps
`include "scl_map.svh"
module scl_host (
  input  wire logic       clk_sys,  // system clock
  input  wire logic       srst,     // sync reset
  input  wire logic       xonMode,  // obey pause/resume
  input  wire logic       slow,     // stall the receiver side
  input  wire logic       rxReady,  // port takes byte
  output logic            rxValid,  // byte offered
  output logic      [7:0] rxData,   // byte offered
  input  wire logic       txValid,  // port sends byte
  input  wire logic [7:0] txData,   // port byte
  output logic            txReady   // we take byte
);
  logic [7:0] got[$];
  logic       held;
  int         hangs;
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    txReady = 1'b1;
    held = 1'b1;
    hangs = 0;
  end
  always @(posedge clk_sys) begin
    txReady <= #1 slow ? ~txReady : 1'b1;
    if (srst)
      held <= 1'b1;
    else if (txValid && txReady) begin
      got.push_back(txData);
      if (txData == `SCL_XON) held <= 1'b0;
      if (txData == `SCL_XOFF) held <= 1'b1;
    end
  end
  // host lines stay short; the bench provokes receive and echo overflow on purpose
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    while (xonMode && held && n < 2000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    rxValid = 1'b1;
    rxData = b;
    while (rxReady !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    #1;
    // a released line shows the inverse, never a stale copy
    rxValid = 1'b0;
    rxData = ~b;
    if (n >= 2000) begin
      hangs++;
      scl_port_tb_top.wrap_up();
    end
  endtask
endmodule

// file: verification/scl_port_tb_top.sv
// testbench for the serial command-line port: table of line exchanges, then edge cases
// assumes scl_host plays the terminal; the bench plays the line parser
`timescale 1ns/1ps
`include "scl_map.svh"
module scl_port_tb_top;
  typedef logic [7:0] scl_bq_t[$];
  typedef struct {logic [2:0] cfg; string din; string tx; string cmd;} scl_row_t;
  logic              clk_sys = 1'b0;
  logic              srst = 1'b1;
  logic              rxValid, rxReady, txValid, txReady, cmdValid, dsr, queueErr;
  logic [7:0]        rxData, txData, cmdData;
  logic              cmdReady = 1'b0;
  logic              cmdDone = 1'b0;
  logic              cfgLoad = 1'b0;
  logic              xonMode = 1'b1;
  logic              slow = 1'b0;
  logic              parserOn = 1'b1;
  scl_pkg::scl_cfg_t cfgIn = '0;
  scl_pkg::scl_cfg_t cfgOut;
  scl_bq_t           cmdGot;
  int                doneCnt = 0;
  int                qErrs = 0;
  int                errors = 0;
  int                tests_run = 0;
  scl_row_t rows[10] = '{
    '{3'h2, "AB\010", "AB\010 \010", ""},
    '{3'h0, "XY\033Z\015", "\015\012\015\012", "Z\015"},
    '{3'h0, "AB\010C\015", "\015\012", "AC\015"},
    '{3'h0, "\001Q\012", "\015\012", "Q\012"},
    '{3'h0, "AB\030C\015", "\015\012", "C\015"},
    '{3'h0, "A\015B\015", "\015\012\015\012", "A\015B\015"},
    '{3'h2, "K\015\012", "K\015\015\012\015\012", "K\015\012"},
    '{3'h4, "V\015", "\023\015\012", "V\015"},
    '{3'h6, "V\015", "V\023\015\015\012", "V\015"},
    '{3'h3, "P\015", "P\015\015\012>", "P\015"}};
  scl_port #(.XON_CYCLES(200)) scl_port_inst (.clk_sys(clk_sys), .srst(srst),
    .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .txValid(txValid),
    .txData(txData), .txReady(txReady), .cmdValid(cmdValid), .cmdData(cmdData),
    .cmdReady(cmdReady), .cmdDone(cmdDone), .cfgLoad(cfgLoad), .cfgIn(cfgIn),
    .cfgOut(cfgOut), .dsr(dsr), .queueErr(queueErr));
  scl_host scl_host_inst (.clk_sys(clk_sys), .srst(srst), .xonMode(xonMode),
    .slow(slow), .rxReady(rxReady), .rxValid(rxValid), .rxData(rxData),
    .txValid(txValid), .txData(txData), .txReady(txReady));
  always #2 clk_sys = ~clk_sys;
  // parser: holds off after each terminator, then reports the line done
  always @(posedge clk_sys) begin
    if (cmdValid && cmdReady) begin
      cmdGot.push_back(cmdData);
      if (cmdData == `SCL_CR || cmdData == `SCL_LF) doneCnt = 4;
    end else if (doneCnt > 0) doneCnt = doneCnt - 1;
    cmdDone <= #1 (doneCnt == 1);
    cmdReady <= #1 parserOn && doneCnt == 0;
    if (queueErr === 1'b1) qErrs++;
  end
  task automatic wrap_up();
    if (errors == 0 && tests_run > 0 && scl_host_inst.hangs == 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // periodic resume bytes are timing dependent, so they are left out here
  task automatic chkq(input string n, input scl_bq_t q, input string e);
    scl_bq_t c;
    foreach (q[i]) if (q[i] !== `SCL_XON) c.push_back(q[i]);
    chk({n, " length"}, 16'(c.size()), 16'(e.len()));
    foreach (c[i]) if (i < e.len()) chk(n, c[i], e[i]);
  endtask
  function automatic int cnt(input scl_bq_t q, input logic [7:0] b);
    cnt = 0;
    foreach (q[i]) if (q[i] === b) cnt++;
  endfunction
  task automatic rst();
    srst = 1'b1;
    xonMode = 1'b1;
    slow = 1'b0;
    parserOn = 1'b1;
    repeat (12) @(posedge clk_sys);
    #1;
    chk("dsr reset", dsr, 0);
    chk("cfg reset", cfgOut, 3'h4);
    srst = 1'b0;
    @(posedge clk_sys);
    #1;
    chk("dsr ready", dsr, 1);
    scl_host_inst.got.delete();
    cmdGot.delete();
    qErrs = 0;
  endtask
  task automatic load(input logic [2:0] c);
    cfgIn = scl_pkg::scl_cfg_t'(c);
    xonMode = c[2];
    cfgLoad = 1'b1;
    @(posedge clk_sys);
    #1;
    cfgLoad = 1'b0;
    chk("cfg", cfgOut, c);
  endtask
  task automatic settle();
    int q;
    int n;
    q = 0;
    n = 0;
    while (q < 8 && n < 1500) begin
      @(posedge clk_sys);
      #1;
      n++;
      q = (dsr === 1'b1 && txValid === 1'b0 && cmdValid === 1'b0 && doneCnt == 0) ? q + 1 : 0;
    end
    if (q < 8) begin
      chk("settle idle", 16'(q), 16'h0008);
      wrap_up();
    end
  endtask
  initial begin
    int n;
    @(posedge clk_sys);
    #1;
    foreach (rows[i]) begin
      rst();
      load(rows[i].cfg);
      for (int j = 0; j < rows[i].din.len(); j++) scl_host_inst.send(rows[i].din[j]);
      settle();
      chkq("tx", scl_host_inst.got, rows[i].tx);
      chkq("cmd", cmdGot, rows[i].cmd);
    end
    // overflow with the parser stalled: oldest bytes go, readiness stays low
    rst();
    load(3'h0);
    parserOn = 1'b0;
    for (int i = 0; i < 300; i++) scl_host_inst.send(8'h40 + 8'(i % 64));
    scl_host_inst.send(`SCL_CR);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("dsr busy", dsr, 0);
    parserOn = 1'b1;
    settle();
    chk("cmd count", 16'(cmdGot.size()), 256);
    chk("oldest kept", cmdGot[0], 8'h40 + 8'd45);
    rst();
    repeat (1000) @(posedge clk_sys);
    #1;
    n = cnt(scl_host_inst.got, `SCL_XON);
    chk("xon repeats", n >= 4 && n <= 6, 1);
    load(3'h0);
    repeat (20) @(posedge clk_sys);
    scl_host_inst.got.delete();
    repeat (1000) @(posedge clk_sys);
    #1;
    chk("xon off", cnt(scl_host_inst.got, `SCL_XON), 0);
    load(3'h2);
    scl_host_inst.send(`SCL_XOFF);
    scl_host_inst.send(8'h41);
    settle();
    chk("pause ignored", cnt(scl_host_inst.got, 8'h41), 1);
    // host checks its echo, then clears the line with escape
    chk("echo back", scl_host_inst.got[scl_host_inst.got.size() - 1], 8'h41);
    scl_host_inst.send(`SCL_ESC);
    settle();
    chk("esc clears", cnt(scl_host_inst.got, `SCL_LF), 1);
    // pause with echo pending, resume with a stalling host
    rst();
    load(3'h6);
    scl_host_inst.send(`SCL_XOFF);
    scl_host_inst.send(8'h41);
    scl_host_inst.send(8'h42);
    // echoes pile up behind the pause until the output queue overflows
    for (int i = 0; i < 64; i++) scl_host_inst.send(8'h43);
    repeat (20) @(posedge clk_sys);
    #1;
    chk("paused", txValid, 0);
    chk("query err", qErrs, 1);
    slow = 1'b1;
    scl_host_inst.send(`SCL_XON);
    settle();
    n = scl_host_inst.got.size() - 1;
    while (n > 0 && scl_host_inst.got[n] === `SCL_XON) n--;
    chk("bang last", scl_host_inst.got[n], `SCL_BANG);
    chk("held byte", cnt(scl_host_inst.got, 8'h42), 1);
    chk("nak sent", cnt(scl_host_inst.got, `SCL_NAK), 1);
    chk("nak logged", qErrs, 2);
    wrap_up();
  end
endmodule
